/* logic/serdes_pkg.sv */
// Purpose: shared constants for the 24-bit embedded clock link
// Assumes: one system clock, serial line runs one bit per system clock
// Notes: frame is sent most significant bit first
//
// Summary of operation
// R1: tx sends 28-bit frames: 24 data bits plus 4 overhead bits.
// R2: first embedded clock bit is always 1, second always 0.
// R3: tx may invert data per frame, flags it; rx undoes inversion.
// R4: tx adds an integrity bit; rx checks it while locking and receiving.
// R5: tx samples data on rising link clock edge if select high, else falling.
// R6: rx recovered clock active edge follows the polarity select input.
// R7: tx drives serial output only when enabled and not powered down.
// R8: rx output enable controls data outputs and recovered clock.
// R9: tx keeps serial output off while its clock lock is acquired.
// R10: during initialization tx sends random non-repeating data.
// R11: rx locks to any data by finding and validating the clock edge.
// R12: rx lock stays low until locked, rises with first valid data.
// R13: rx data valid only while lock is high.
// R14: rx data outputs are synchronous to the recovered clock.
// R15: one missed embedded edge drops lock and restarts the hunt.
// R16: tx powerdown stops it and floats output; relocks on release.
// R17: rx powerdown stops it and floats outputs; release brings it back.
// R18: after powerdown both ends relock; rx lock only when truly locked.
// R19: source must supply link clock between 5 MHz and 43 MHz.
// R20: source gives meaningful data only after tx has locked.
// R21: rx lock output stays driven while other outputs are floated.
// R22: tx enable returning high resumes state without reinitializing.
// R23: frame bit order is a fixed layout shared by both ends.
// R24: tx inverts when sending plain data would grow running disparity.
package serdes_pkg;
  localparam int DATA_W = 24;
  localparam int FRAME_W = 28;
  // frame layout, index 27 leaves the wire first
  localparam int POS_EDGE_HI = 27;
  localparam int POS_DATA_LO = 3;
  localparam int POS_INVERT = 2;
  localparam int POS_CHECK = 1;
  localparam int POS_EDGE_LO = 0;
  localparam int HALF_FRAME = 14;
  // register addresses, control and status register bits
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_TX_PDN = 1;
  localparam int CTRL_TX_EDGE = 2;
  localparam int CTRL_RX_EN = 3;
  localparam int CTRL_RX_PDN = 4;
  localparam int CTRL_RX_POL = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int ST_TX_PLL = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_RX_LOCK = 2;
  localparam int ST_LOSS_LO = 8;
  // timing counts and the LFSR seed
  localparam int TX_PLL_LOCK_EDGES = 16;
  localparam int TX_INIT_FRAMES = 4;
  localparam int RX_LOCK_FRAMES = 4;
  localparam logic [23:0] LFSR_SEED = 24'hA5C31E;
  typedef enum logic [1:0]
  {
    TX_OFF = 2'b00,
    TX_PLL = 2'b01,
    TX_INIT = 2'b10,
    TX_RUN = 2'b11
  } tx_state_e;
  typedef enum logic [1:0]
  {
    RX_OFF = 2'b00,
    RX_HUNT = 2'b01,
    RX_CONFIRM = 2'b10,
    RX_LOCKED = 2'b11
  } rx_state_e;
endpackage

/* logic/frame_tx_if.sv */
// Purpose: carries frame words between link control and the frame sender
// Assumes: both ends on i_clk
// Notes: take pulses when a word is consumed at frame start
`timescale 1ns/1ns
interface frame_tx_if import serdes_pkg::*;;
  logic run;
  logic [DATA_W-1:0] word;
  logic take;
  logic bit_o;
  modport tx(input run, input word, output take, output bit_o);
  modport ctl(output run, output word, input take, input bit_o);
endinterface

/* logic/frame_tx.sv */
// Purpose: encodes and shifts out 28-bit frames
// Assumes: one serial bit per clock
// Notes: disparity kept in a signed running count
`timescale 1ns/1ns
module frame_tx
  import serdes_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  frame_tx_if.tx f
);
  logic [FRAME_W-1:0] sr_q;
  logic [4:0] cnt_q;
  logic signed [7:0] rd_q;
  logic take_q;
  logic bit_q;
  logic [4:0] pop;
  logic signed [7:0] disp;
  logic inv;
  logic [DATA_W-1:0] pay;
  logic [FRAME_W-1:0] frame;

  always_comb
  begin
    pop = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      pop = pop + 5'(f.word[i]);
    end
    disp = $signed({2'b00, pop, 1'b0}) - 8'sd24;
    inv = (rd_q > 0 && disp > 0) || (rd_q < 0 && disp < 0); // R24 R3
    pay = inv ? ~f.word : f.word;
    frame = {1'b1, pay, inv, ^{pay, inv}, 1'b0}; // R2 R4 R23
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !f.run)
    begin
      cnt_q <= '0;
      sr_q <= '0;
      take_q <= 1'b0;
      bit_q <= 1'b0;
    end
    else if (cnt_q == 5'd0)
    begin
      sr_q <= frame;
      bit_q <= frame[POS_EDGE_HI];
      take_q <= 1'b1;
      cnt_q <= 5'd1;
    end
    else
    begin
      sr_q <= {sr_q[FRAME_W-2:0], 1'b0};
      bit_q <= sr_q[FRAME_W-2];
      take_q <= 1'b0;
      cnt_q <= (cnt_q == 5'(FRAME_W - 1)) ? 5'd0 : cnt_q + 5'd1; // R1
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rd_q <= '0;
    else if (f.run && cnt_q == 5'd0)
      rd_q <= inv ? rd_q - disp : rd_q + disp; // R24
  end

  assign f.take = take_q;
  assign f.bit_o = bit_q;

  property p_edge_first;
    @(posedge i_clk) disable iff (i_sys_rst)
      take_q |-> bit_q && !sr_q[POS_EDGE_LO];
  endproperty
  a_edge_first: assert property (p_edge_first) // R2
    else $error("frame does not open with the embedded edge");

  property p_frame_len;
    @(posedge i_clk) disable iff (i_sys_rst)
      (f.run && cnt_q == 5'(FRAME_W - 1)) ##1 f.run |=> take_q;
  endproperty
  a_frame_len: assert property (p_frame_len) // R1
    else $error("frame length is not 28 bits");

  property p_check_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
      take_q |-> (^sr_q) == 1'b1;
  endproperty
  a_check_bit: assert property (p_check_bit) // R4
    else $error("integrity bit wrong");

  property p_balance;
    @(posedge i_clk) disable iff (i_sys_rst)
      rd_q <= 8'sd48 && rd_q >= -8'sd48;
  endproperty
  a_balance: assert property (p_balance) // R3
    else $error("running disparity out of bound");
endmodule

/* logic/serdes_link.sv */
// Purpose: transmitter and receiver of the embedded clock serial link
// Assumes: link clock and pins asynchronous, sampled by two flip-flops
// Notes: one serial bit per i_clk; link clock must stay under i_clk/28
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
module serdes_link
  import serdes_pkg::*;
#(
  parameter int LOCK_FRAMES = RX_LOCK_FRAMES,
  parameter int PLL_EDGES = TX_PLL_LOCK_EDGES,
  parameter int INIT_FRAMES = TX_INIT_FRAMES
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_tx_parallel_clock,
  input wire logic [DATA_W-1:0] i_tx_parallel_in,
  output logic o_serial_out,
  output logic o_serial_oe,
  input wire logic i_serial_line_in,
  output logic [DATA_W-1:0] o_rx_parallel_out,
  output logic o_rx_parallel_oe,
  output logic o_rx_clk,
  output logic o_rx_clk_oe,
  output logic o_rx_lock
);
  if (LOCK_FRAMES < 2 || LOCK_FRAMES > 255 || PLL_EDGES < 1 ||
      PLL_EDGES > 255 || INIT_FRAMES < 1 || INIT_FRAMES > 255)
  begin
    $error("serdes_link: count parameter out of range");
  end

  function automatic logic frame_ok(input logic [FRAME_W-1:0] fr);
    frame_ok = fr[POS_EDGE_HI] && !fr[POS_EDGE_LO] && (^fr); // R11 R4
  endfunction

  frame_tx_if f ();
  frame_tx u_tx
  (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .f(f)
  );

  logic [5:0] ctrl_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] loss_q;
  logic wb_req;
  tx_state_e tx_st_q;

  assign wb_req = i_wb_cyc && i_wb_stb && !ack_q;

  // answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end
    else
    begin
      ack_q <= wb_req;
      rdat_q <= '0;
      if (wb_req && !i_wb_we && i_wb_adr == ADR_CTRL)
        rdat_q <= {26'h0000000, ctrl_q};
      else if (wb_req && !i_wb_we && i_wb_adr == ADR_STATUS)
        rdat_q <= {16'h0000, loss_q, 5'h00, o_rx_lock,
          tx_st_q == TX_RUN, tx_st_q[1]};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ctrl_q <= CTRL_RST;
    else if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == ADR_CTRL)
      ctrl_q <= i_wb_dat[5:0];
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  // link clock and parallel input synchronisers
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_s3_q;
  logic [DATA_W-1:0] din_s1_q;
  logic [DATA_W-1:0] din_s2_q;
  logic [DATA_W-1:0] cap_q;
  logic rise;
  logic fall;
  logic strobe;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      din_s1_q <= '0;
      din_s2_q <= '0;
    end
    else
    begin
      clk_s1_q <= i_tx_parallel_clock;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      din_s1_q <= i_tx_parallel_in;
      din_s2_q <= din_s1_q;
    end
  end

  assign rise = clk_s2_q && !clk_s3_q;
  assign fall = !clk_s2_q && clk_s3_q;
  assign strobe = ctrl_q[CTRL_TX_EDGE] ? rise : fall; // R5

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      cap_q <= '0;
    else if (strobe)
      cap_q <= din_s2_q; // R5
  end

  // transmitter sequencing
  logic [7:0] tx_cnt_q;
  logic [DATA_W-1:0] lfsr_q;
  logic tx_on;

  assign tx_on = ctrl_q[CTRL_TX_PDN];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !tx_on)
    begin
      tx_st_q <= TX_OFF; // R16
      tx_cnt_q <= '0;
    end
    else
    begin
      case (tx_st_q)
        TX_OFF:
        begin
          tx_st_q <= TX_PLL; // R18
          tx_cnt_q <= '0;
        end
        TX_PLL:
        begin
          if (rise && tx_cnt_q == 8'(PLL_EDGES - 1))
          begin
            tx_st_q <= TX_INIT; // R9 R16
            tx_cnt_q <= '0;
          end
          else if (rise)
            tx_cnt_q <= tx_cnt_q + 8'd1;
        end
        TX_INIT:
        begin
          if (f.take && tx_cnt_q == 8'(INIT_FRAMES - 1))
            tx_st_q <= TX_RUN;
          else if (f.take)
            tx_cnt_q <= tx_cnt_q + 8'd1;
        end
        TX_RUN:
          tx_st_q <= TX_RUN;
        default:
          tx_st_q <= TX_OFF;
      endcase
    end
  end

  // pseudo random words keep the initialization stream non-repetitive
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      lfsr_q <= LFSR_SEED;
    else if (f.take)
      lfsr_q <= {lfsr_q[22:0],
        lfsr_q[23] ^ lfsr_q[22] ^ lfsr_q[21] ^ lfsr_q[16]}; // R10
  end

  assign f.run = tx_st_q[1];
  assign f.word = (tx_st_q == TX_INIT) ? lfsr_q : cap_q; // R10

  // enable only gates the driver, so sequencing carries on unseen
  logic ser_q;
  logic ser_oe_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ser_q <= 1'b0;
      ser_oe_q <= 1'b0;
    end
    else
    begin
      ser_q <= f.bit_o;
      ser_oe_q <= ctrl_q[CTRL_TX_EN] && tx_on && tx_st_q[1]; // R7 R9 R22
    end
  end

  assign o_serial_out = ser_q;
  assign o_serial_oe = ser_oe_q;

  // receiver
  logic rin_s1_q;
  logic rin_s2_q;
  logic [FRAME_W-1:0] sr_q;
  rx_state_e rx_st_q;
  logic [4:0] ph_q;
  logic [4:0] ph_d;
  logic [7:0] hits_q;
  logic lock_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] dec;
  logic rclk_q;
  logic rx_oe_q;
  logic rx_on;
  logic good;
  logic boundary;

  assign rx_on = ctrl_q[CTRL_RX_PDN];
  assign good = frame_ok(sr_q);
  assign boundary = (ph_q == 5'd0);
  assign ph_d = (ph_q == 5'(FRAME_W - 1)) ? 5'd0 : ph_q + 5'd1;
  assign dec = sr_q[POS_INVERT] ? ~sr_q[POS_EDGE_HI-1:POS_DATA_LO]
    : sr_q[POS_EDGE_HI-1:POS_DATA_LO]; // R3

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rin_s1_q <= 1'b0;
      rin_s2_q <= 1'b0;
      sr_q <= '0;
    end
    else
    begin
      rin_s1_q <= i_serial_line_in;
      rin_s2_q <= rin_s1_q;
      sr_q <= {sr_q[FRAME_W-2:0], rin_s2_q};
    end
  end

  // lock needs several aligned good frames; random data rarely passes
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !rx_on)
    begin
      rx_st_q <= RX_OFF; // R17
      ph_q <= '0;
      hits_q <= '0;
      lock_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ph_q <= ph_d;
      case (rx_st_q)
        RX_OFF:
          rx_st_q <= RX_HUNT; // R18
        RX_HUNT:
        begin
          if (good)
          begin
            rx_st_q <= RX_CONFIRM; // R11
            ph_q <= 5'd1;
            hits_q <= 8'd1;
          end
        end
        RX_CONFIRM:
        begin
          if (boundary && !good)
            rx_st_q <= RX_HUNT;
          else if (boundary && hits_q == 8'(LOCK_FRAMES - 1))
          begin
            rx_st_q <= RX_LOCKED;
            lock_q <= 1'b1; // R12
            rdata_q <= dec; // R12
          end
          else if (boundary)
            hits_q <= hits_q + 8'd1;
        end
        RX_LOCKED:
        begin
          if (boundary && !good)
          begin
            rx_st_q <= RX_HUNT; // R15
            lock_q <= 1'b0; // R15 R13
          end
          else if (boundary)
            rdata_q <= dec; // R13
        end
        default:
          rx_st_q <= RX_OFF;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      loss_q <= '0;
    else if (rx_st_q == RX_LOCKED && boundary && !good && loss_q != 8'hFF)
      loss_q <= loss_q + 8'd1;
  end

  // active edge falls mid-frame so data is settled around it
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rclk_q <= 1'b0;
    else if (lock_q)
      rclk_q <= (ph_d >= 5'(HALF_FRAME)) ~^ ctrl_q[CTRL_RX_POL]; // R6 R14
    else
      rclk_q <= !ctrl_q[CTRL_RX_POL]; // R6
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rx_oe_q <= 1'b0;
    else
      rx_oe_q <= ctrl_q[CTRL_RX_EN] && rx_on; // R8 R17
  end

  assign o_rx_parallel_out = rdata_q; // R14
  assign o_rx_parallel_oe = rx_oe_q;
  assign o_rx_clk = rclk_q;
  assign o_rx_clk_oe = rx_oe_q; // R8
  assign o_rx_lock = lock_q; // R21

  property p_tx_gate;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_serial_oe |-> $past(ctrl_q[CTRL_TX_EN]) && $past(tx_st_q[1]);
  endproperty
  a_tx_gate: assert property (p_tx_gate) // R7
    else $error("serial driver on while disabled");

  property p_tx_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
      (tx_st_q == TX_PLL) |=> !o_serial_oe;
  endproperty
  a_tx_quiet: assert property (p_tx_quiet) // R9
    else $error("serial driver on before clock lock");

  property p_tx_pd;
    @(posedge i_clk) disable iff (i_sys_rst)
      !ctrl_q[CTRL_TX_PDN] |=> tx_st_q == TX_OFF ##1 !o_serial_oe;
  endproperty
  a_tx_pd: assert property (p_tx_pd) // R16
    else $error("tx powerdown not honoured");

  property p_lock_data;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_rx_lock) |-> $past(good) && $past(boundary) &&
        o_rx_parallel_out == $past(dec);
  endproperty
  a_lock_data: assert property (p_lock_data) // R12
    else $error("lock rose without valid data");

  property p_miss;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rx_st_q == RX_LOCKED && boundary && !good && rx_on) |=>
        !o_rx_lock && rx_st_q == RX_HUNT;
  endproperty
  a_miss: assert property (p_miss) // R15
    else $error("missed edge did not drop lock");

  property p_rx_pd;
    @(posedge i_clk) disable iff (i_sys_rst)
      !rx_on |=> !o_rx_lock && !o_rx_parallel_oe;
  endproperty
  a_rx_pd: assert property (p_rx_pd) // R17
    else $error("rx powerdown not honoured");

  property p_rx_oe_pair;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_rx_parallel_oe == o_rx_clk_oe;
  endproperty
  a_rx_oe_pair: assert property (p_rx_oe_pair) // R8
    else $error("data and clock enables differ");

  property p_capture;
    @(posedge i_clk) disable iff (i_sys_rst)
      strobe |=> cap_q == $past(din_s2_q);
  endproperty
  a_capture: assert property (p_capture) // R5
    else $error("parallel word not captured on selected edge");
endmodule

/* testbench/serdes_peer.sv */
// Purpose: far-end serializer that feeds the receiver of serdes_link
// Assumes: one serial bit per i_clk, frames back to back
// Notes: i_bad clears the high embedded bit of the next frame
`timescale 1ns/1ns
module serdes_peer
  import serdes_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [DATA_W-1:0] i_word,
  input wire logic i_bad,
  output logic o_line
);
  logic [4:0] pos_q;
  logic [FRAME_W-1:0] sh_q;
  logic [FRAME_W-1:0] frame_d;
  logic [DATA_W-1:0] pay;
  logic bad_q;
  logic inv;
  int disp_q;
  int diff;
  always_comb
  begin
    diff = 2 * $countones(i_word) - DATA_W;
    inv = (diff > 0 && disp_q > 0) || (diff < 0 && disp_q < 0);
    pay = inv ? ~i_word : i_word;
    frame_d[POS_EDGE_HI] = ~bad_q;
    frame_d[POS_DATA_LO +: DATA_W] = pay;
    frame_d[POS_INVERT] = inv;
    frame_d[POS_CHECK] = ^{pay, inv};
    frame_d[POS_EDGE_LO] = 1'b0;
  end
  // the pulse is remembered until a frame can carry the fault
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pos_q <= 5'h0;
      sh_q <= '0;
      bad_q <= 1'b0;
      disp_q <= 0;
      o_line <= 1'b0;
    end
    else if (pos_q == 5'h0)
    begin
      o_line <= frame_d[FRAME_W-1];
      sh_q <= frame_d << 1;
      disp_q <= disp_q + (inv ? -diff : diff);
      bad_q <= i_bad;
      pos_q <= 5'h1;
    end
    else
    begin
      o_line <= sh_q[FRAME_W-1];
      sh_q <= sh_q << 1;
      bad_q <= bad_q | i_bad;
      pos_q <= (pos_q == 5'h1B) ? 5'h0 : pos_q + 5'h1;
    end
  end
endmodule

/* testbench/serdes_link_test.sv */
// Purpose: self-checking bench for serdes_link
// Assumes: peer model drives the serial input, link clock 80 ns
// Notes: first tx frame bit trails the rise of the serial enable by one clock
`timescale 1ns/1ns
module serdes_link_test import serdes_pkg::*;;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic lclk = 1'b0;
  logic bad = 1'b0;
  logic mix = 1'b1;
  logic [2:0] ph = 3'h0;
  logic [23:0] din = 24'h0;
  logic [23:0] wd_a, wd_b, pw, d1, d2;
  logic [31:0] rdat;
  logic ack, sout, soe, sin, rclk, rclk_oe, rx_oe, lock;
  logic [23:0] rx_parallel_out;
  logic [31:0] seed = 32'd76172;
  logic [31:0] rd_q[$];
  logic [27:0] fr_q[$];
  logic [27:0] sh = 28'h0;
  logic [27:0] f;
  int err_count = 0;
  int checked = 0;
  int fpos = 0;
  serdes_link dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_tx_parallel_clock(lclk), .i_tx_parallel_in(din),
    .o_serial_out(sout), .o_serial_oe(soe), .i_serial_line_in(sin),
    .o_rx_parallel_out(rx_parallel_out), .o_rx_parallel_oe(rx_oe), .o_rx_clk(rclk),
    .o_rx_clk_oe(rclk_oe), .o_rx_lock(lock));
  serdes_peer peer_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_word(pw),
    .i_bad(bad), .o_line(sin));
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [23:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[23:0];
  endfunction
  task automatic final_report();
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic pick(input int s);
    return s ? lock : soe;
  endfunction
  task automatic wait_for(input int s, input logic v, input int n);
    int i;
    i = 0;
    while (pick(s) !== v && i < n)
    begin
      @(posedge i_clk);
      i++;
    end
    chk({31'h0, pick(s)}, {31'h0, v});
  endtask
  // fresh words while hunting, so no false alignment can stay good
  task automatic relock();
    mix <= 1'b1;
    wait_for(1, 1'b1, 3000);
    mix <= 1'b0;
    repeat (90) @(posedge i_clk);
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    if (!w)
      rd_q.push_back(d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= w ? d : 32'h0;
    @(posedge i_clk);
    while (ack !== 1'b1)
      @(posedge i_clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic frame(input logic use_e, input logic [23:0] e,
    output logic [23:0] d);
    int i;
    i = 0;
    while (fr_q.size() == 0 && i < 200)
    begin
      @(posedge i_clk);
      i++;
    end
    f = (fr_q.size() > 0) ? fr_q.pop_front() : 28'h0;
    d = f[POS_DATA_LO +: DATA_W];
    if (f[POS_INVERT])
      d = ~d;
    chk(f[POS_EDGE_HI], 32'h1);
    chk(f[POS_EDGE_LO], 32'h0);
    chk(^f[POS_EDGE_HI-1:POS_CHECK], 32'h0);
    if (use_e)
      chk(d, e);
  endtask
  // data settles mid-phase so each strobe edge sees one stable word
  always @(posedge i_clk)
  begin
    ph <= ph + 3'h1;
    lclk <= (ph < 3'h4);
    din <= (soe !== 1'b1) ? 24'h0 :
      (ph >= 3'h3 && ph <= 3'h6) ? wd_a : wd_b;
    if (mix)
      pw <= rnd();
  end
  always @(posedge i_clk)
  begin
    if (ack === 1'b1 && cyc && !we && rd_q.size() > 0)
      chk(rdat, rd_q.pop_front());
    sh = {sh[26:0], sout};
    if (soe !== 1'b1)
      fpos = -1;
    else if (fpos == 27)
    begin
      fr_q.push_back(sh);
      fpos = 0;
    end
    else
      fpos++;
  end
  initial
  begin
    #400000;
    err_count++;
    final_report();
  end
  initial
  begin
    wd_a = rnd();
    wd_b = rnd();
    pw = rnd();
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    wb(1'b0, ADR_CTRL, {26'h0, CTRL_RST});
    wb(1'b0, ADR_STATUS, 32'h0);
    wb(1'b1, 4'h8, 32'hFF);
    wb(1'b0, 4'h8, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h3F);
    repeat (2) @(posedge i_clk);
    chk(lock, 32'h0);
    chk(rclk, 32'h0);
    repeat (100) @(posedge i_clk);
    chk(soe, 32'h0);
    wait_for(0, 1'b1, 400);
    frame(1'b0, 24'h0, d1);
    frame(1'b0, 24'h0, d2);
    chk({31'h0, d1 === d2}, 32'h0);
    repeat (2) frame(1'b0, 24'h0, d1);
    repeat (3) frame(1'b1, wd_b, d1);
    relock();
    chk(rx_parallel_out, pw);
    pw <= rnd();
    repeat (90) @(posedge i_clk);
    chk(rx_parallel_out, pw);
    bad <= 1'b1;
    @(posedge i_clk);
    bad <= 1'b0;
    wait_for(1, 1'b0, 100);
    relock();
    wb(1'b0, ADR_STATUS, 32'h107);
    wb(1'b1, ADR_CTRL, 32'h37);
    repeat (3) @(posedge i_clk);
    chk(rx_oe, 32'h0);
    chk(rclk_oe, 32'h0);
    chk(lock, 32'h1);
    wb(1'b1, ADR_CTRL, 32'h3E);
    repeat (3) @(posedge i_clk);
    chk(soe, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h107);
    wb(1'b1, ADR_CTRL, 32'h3F);
    repeat (4) @(posedge i_clk);
    chk(soe, 32'h1);
    wb(1'b1, ADR_CTRL, 32'h3D);
    repeat (3) @(posedge i_clk);
    chk(soe, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h104);
    fr_q.delete();
    wb(1'b1, ADR_CTRL, 32'h3B);
    wait_for(0, 1'b1, 400);
    repeat (4) frame(1'b0, 24'h0, d1);
    repeat (2) frame(1'b1, wd_a, d1);
    wb(1'b1, ADR_CTRL, 32'h0B);
    repeat (3) @(posedge i_clk);
    chk(lock, 32'h0);
    chk(rx_oe, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h1B);
    repeat (3) @(posedge i_clk);
    chk(lock, 32'h0);
    chk(rclk, 32'h1);
    chk(rclk_oe, 32'h1);
    relock();
    chk(rx_parallel_out, pw);
    final_report();
  end
endmodule
